// *** inc/sspi_pkg.sv ***
// shared constants of the synchronous serial port in spi mode
package sspi_pkg;
   // register indices on the software port
   localparam logic [2:0] REG_FLAGS   = 3'h0;   // peripheral_irq_flags
   localparam logic [2:0] REG_ENABLES = 3'h1;   // peripheral_irq_enables
   localparam logic [2:0] REG_BUFFER  = 3'h2;   // serial_transfer_buffer
   localparam logic [2:0] REG_CONTROL = 3'h3;   // serial_port_control
   localparam logic [2:0] REG_STATUS  = 3'h4;   // serial_port_status
   // field positions
   localparam int IRQ_BIT   = 3;
   localparam int WRITE_COLLISION_FLAG_BIT  = 7;
   localparam int OVF_BIT   = 6;
   localparam int EN_BIT    = 5;
   localparam int CPOL_BIT  = 4;
   localparam int SMP_BIT   = 7;
   localparam int CKE_BIT   = 6;
   localparam int BF_BIT    = 0;
   localparam logic [7:0] CTL_RESET  = 8'h00;
   localparam logic [1:0] STAT_RESET = 2'h0;
   // mode field codes
   localparam logic [3:0] MODE_M_DIV4  = 4'h0;
   localparam logic [3:0] MODE_M_DIV16 = 4'h1;
   localparam logic [3:0] MODE_M_DIV64 = 4'h2;
   localparam logic [3:0] MODE_M_TIMER_TWO  = 4'h3;
   localparam logic [3:0] MODE_S_SEL   = 4'h4;
   localparam logic [3:0] MODE_S_NOSEL = 4'h5;
   // half bit periods in clock cycles, minus one, for the oscillator rates
   localparam logic [5:0] HALF_DIV4  = 6'h01;
   localparam logic [5:0] HALF_DIV16 = 6'h07;
   localparam logic [5:0] HALF_DIV64 = 6'h1f;
   // a byte is eight bits, sixteen serial clock edges
   localparam int         BYTE_BITS  = 8;
   localparam logic [4:0] BYTE_EDGES = 5'h10;
endpackage

// *** inc/sspi_link_if.sv ***
// serial link between the port and its partner, with pin resolution
`timescale 1ns/1ps
interface sspi_link_if;
   logic dev_sck;       // port clock drive value
   logic dev_sck_oe_n;  // port clock drive enable, low drives
   logic par_sck;       // partner clock drive value
   logic par_sck_oe_n;  // partner clock drive enable, low drives
   logic sck;           // resolved clock wire
   logic dev_sdo;       // port data out
   logic dev_sdo_oe_n;  // port data out enable, low drives
   logic par_sdo;       // partner data out
   logic par_sdo_oe_n;  // partner data out enable, low drives
   logic dev_sdi;       // data seen by the port
   logic par_sdi;       // data seen by the partner
   logic ss_n;          // slave select from the partner, active low

   // undriven wires float to the pull-up level
   assign sck     = !dev_sck_oe_n ? dev_sck : (!par_sck_oe_n ? par_sck : 1'b1);
   assign dev_sdi = !par_sdo_oe_n ? par_sdo : 1'b1;
   assign par_sdi = !dev_sdo_oe_n ? dev_sdo : 1'b1;

   modport port (output dev_sck, dev_sck_oe_n, dev_sdo, dev_sdo_oe_n, input sck, dev_sdi, ss_n);
   modport partner (output par_sck, par_sck_oe_n, par_sdo, par_sdo_oe_n, ss_n, input sck, par_sdi);
endinterface

// *** logic/sspi_partner.sv ***
// partner end: a plain spi master or slave facing the serial port
`timescale 1ns/1ps
module sspi_partner (
   input  wire logic         clk,       // 200 MHz clock
   input  wire logic         rstn,      // async reset, active low
   input  wire logic         p_master,  // 1 drives the clock, 0 follows it
   input  wire logic         p_cpol,    // idle level of the clock
   input  wire logic         p_cke,     // 1 data valid before first edge
   input  wire logic [7:0]   p_half,    // half bit period in cycles minus one
   input  wire logic         start,     // pulse, begin a master byte
   input  wire logic [7:0]   tx_byte,   // byte to send
   output logic [7:0]        rx_byte,   // last byte received
   output logic              done,      // pulse, byte complete
   output logic              busy,      // byte in progress
   sspi_link_if.partner      link       // serial pins
);
   typedef struct packed {
      logic [7:0] sr;
      logic       in_bit;
      logic [4:0] edges;
      logic       active;
      logic [7:0] div;
      logic       sck_q;
      logic       sck_prev;
      logic       ss_n;
      logic [7:0] rx;
      logic       done;
      logic       sdi_q;
   } sspi_par_s;

   sspi_par_s st_r;
   sspi_par_s st_nxt;
   logic      edge_ev;
   logic      lead;
   logic      chg;
   logic      smp_bit;
   logic [4:0] n;

   always_comb begin
      st_nxt   = st_r;
      edge_ev  = 1'b0;
      lead     = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.sck_prev = link.sck;
      // data as it stood beside the previous clock sample, the level at the seen edge
      st_nxt.sdi_q    = link.par_sdi;
      if (p_master) begin
         if (!st_r.active) begin
            st_nxt.sck_q = p_cpol;
            st_nxt.ss_n  = 1'b1;   // select rises only after the last edge was seen
            if (start) begin
               st_nxt.sr     = tx_byte;
               st_nxt.active = 1'b1;
               st_nxt.ss_n   = 1'b0;   // select always driven so the port may use select control
               st_nxt.div    = p_half;
               st_nxt.edges  = '0;
            end
         end else if (st_r.div == '0) begin
            st_nxt.div   = p_half;
            st_nxt.sck_q = !st_r.sck_q;
            edge_ev      = 1'b1;
            lead         = (st_r.sck_q == p_cpol);
         end else begin
            st_nxt.div = st_r.div - 8'h01;
         end
      end else begin
         st_nxt.ss_n  = 1'b1;
         st_nxt.sck_q = p_cpol;   // idle level ready, so turning master moves no edge
         // a byte opens with a leading edge; a step back to idle is the port taking the pin
         if (link.sck != st_r.sck_prev && (link.sck != p_cpol || st_r.edges != '0)) begin
            edge_ev = 1'b1;
            lead    = (link.sck != p_cpol);
            st_nxt.active = 1'b1;
         end
      end
      // same shift and latch edges as the port, same polarity
      chg = lead ^ p_cke;
      // a follower sees edges a cycle late, after the far end may have moved its data
      smp_bit = p_master ? link.par_sdi : st_r.sdi_q;
      n   = st_r.edges + 5'h01;
      if (edge_ev) begin
         st_nxt.edges = n;
         if (n == sspi_pkg::BYTE_EDGES) begin
            st_nxt.rx     = chg ? {st_r.sr[6:0], st_r.in_bit} : {st_r.sr[6:0], smp_bit};
            st_nxt.done   = 1'b1;
            st_nxt.edges  = '0;
            st_nxt.active = 1'b0;
            if (!p_master) st_nxt.sr = tx_byte;
         end else if (chg) begin
            if (p_cke || n != 5'h01) st_nxt.sr = {st_r.sr[6:0], st_r.in_bit};
         end else begin
            st_nxt.in_bit = smp_bit;
         end
      end
      if (!p_master && !st_r.active && st_r.edges == '0 && !edge_ev) st_nxt.sr = tx_byte;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{sr: 8'h00, in_bit: 1'b0, edges: 5'h00, active: 1'b0, div: 8'h00,
                   sck_q: 1'b0, sck_prev: 1'b1, ss_n: 1'b1, rx: 8'h00, done: 1'b0, sdi_q: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   // clock pin is an output only as master
   assign link.par_sck      = st_r.sck_q;
   assign link.par_sck_oe_n = !p_master;
   assign link.par_sdo      = st_r.sr[7];
   assign link.par_sdo_oe_n = 1'b0;
   assign link.ss_n         = st_r.ss_n;
   assign rx_byte           = st_r.rx;
   assign done              = st_r.done;
   assign busy              = st_r.active;
endmodule

// *** logic/sspi_port.sv ***
// serial port end: spi master/slave with buffer, flags and register port
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - eight bits shifted msb first, both directions
// - full byte goes to buffer and sets full only if buffer empty; irq either way
// - buffer write while busy ignored, sets collision
// - reading buffer clears full flag
// - shift register reached only via buffer
// - enable hands pins to port; reconfigure disabled
// - module reset zeroes bit counter
// - master starts on buffer write, makes clock
// - master rate div4, div16, div64, timer/2
// - polarity bit sets clock idle level
// - edge select 1 gives data before edge
// - status top bits choose sample phase, edge
// - slave shifts on external clock, irq at end
// - slave select low drives data, high floats
// - high select resets slave serial logic
// - partner enables select control when edge 1
// - master freezes during sleep, then resumes
// - slave keeps shifting in sleep, wakes device
// - reset disables port, clears control, status
// - master without data out still receives bytes
// - both ends share edges and clock polarity
// - partner software sets pin directions properly
// - mode field decodes master rates and slaves
module sspi_port (
   input  wire logic         clk,        // 200 MHz clock
   input  wire logic         rstn,       // async reset, active low
   input  wire logic [2:0]   sw_addr,    // register index
   input  wire logic [7:0]   sw_wdata,   // write data
   input  wire logic         sw_wr,      // write strobe
   input  wire logic         sw_rd,      // read strobe
   output logic [7:0]        sw_rdata,   // read data, cycle after strobe
   input  wire logic         sleep_in,   // device asleep
   input  wire logic         timer_two_tick,  // timer two output pulse
   input  wire logic         sdo_off,    // data out pin given back to port logic
   output logic              wake,       // irq flag and enable, wakes device
   sspi_link_if.port         link        // serial pins
);
   typedef struct packed {
      logic [7:0] sr;
      logic [7:0] buffer;
      logic       in_bit;
      logic [4:0] edges;
      logic       active;
      logic [5:0] div;
      logic       sck_q;
      logic       sck_prev;
      logic       sck_oe_n;
      logic       sdo_oe_n;
      logic [7:0] ctl;
      logic [1:0] stat_hi;
      logic       bf;
      logic       irq;
      logic       irq_en;
      logic       wake;
      logic [7:0] rdata;
   } sspi_dev_s;

   sspi_dev_s  st_r;
   sspi_dev_s  st_nxt;
   logic       en;
   logic       cpol;
   logic       cke;
   logic       input_sample_phase;
   logic [3:0] mode;
   logic       master;
   logic       sel_ctl;
   logic       busy;
   logic       edge_ev;
   logic       lead;
   logic       chg;
   logic [4:0] n;
   logic [7:0] byte_in;

   // half period reload per master rate
   function automatic logic [5:0] half_of(input logic [3:0] m);
      case (m)
         sspi_pkg::MODE_M_DIV16: half_of = sspi_pkg::HALF_DIV16;
         sspi_pkg::MODE_M_DIV64: half_of = sspi_pkg::HALF_DIV64;
         default:                half_of = sspi_pkg::HALF_DIV4;
      endcase
   endfunction

   // register read mux; unmapped indices read zero
   function automatic logic [7:0] rd_mux(input sspi_dev_s s, input logic [2:0] a);
      case (a)
         sspi_pkg::REG_FLAGS:   rd_mux = 8'(s.irq) << sspi_pkg::IRQ_BIT;
         sspi_pkg::REG_ENABLES: rd_mux = 8'(s.irq_en) << sspi_pkg::IRQ_BIT;
         sspi_pkg::REG_BUFFER:  rd_mux = s.buffer;   // shift register never visible
         sspi_pkg::REG_CONTROL: rd_mux = s.ctl;
         sspi_pkg::REG_STATUS:  rd_mux = {s.stat_hi, 5'h00, s.bf};
         default:               rd_mux = 8'h00;
      endcase
   endfunction

   assign en      = st_r.ctl[sspi_pkg::EN_BIT];
   assign cpol    = st_r.ctl[sspi_pkg::CPOL_BIT];
   assign mode    = st_r.ctl[3:0];
   assign input_sample_phase     = st_r.stat_hi[sspi_pkg::SMP_BIT - 6];
   assign cke     = st_r.stat_hi[sspi_pkg::CKE_BIT - 6];
   // 0000..0011 master, 0100 slave with select, 0101 slave without
   assign master  = (mode <= sspi_pkg::MODE_M_TIMER_TWO);
   assign sel_ctl = (mode == sspi_pkg::MODE_S_SEL);
   assign busy    = st_r.active || (st_r.edges != '0);

   always_comb begin
      st_nxt   = st_r;
      edge_ev  = 1'b0;
      lead     = 1'b0;
      st_nxt.sck_prev = link.sck;

      // software writes first so hardware sets below win
      if (sw_wr) begin
         case (sw_addr)
            sspi_pkg::REG_FLAGS:   st_nxt.irq = sw_wdata[sspi_pkg::IRQ_BIT];
            sspi_pkg::REG_ENABLES: st_nxt.irq_en = sw_wdata[sspi_pkg::IRQ_BIT];
            sspi_pkg::REG_CONTROL: st_nxt.ctl = sw_wdata;
            sspi_pkg::REG_STATUS:  st_nxt.stat_hi = sw_wdata[7:6];
            sspi_pkg::REG_BUFFER: begin
               if (busy || !en) begin
                  if (busy) st_nxt.ctl[sspi_pkg::WRITE_COLLISION_FLAG_BIT] = 1'b1;
               end else begin
                  st_nxt.sr = sw_wdata;   // buffer keeps the last received byte
                  if (master) begin
                     st_nxt.active = 1'b1;
                     st_nxt.div    = half_of(mode);
                  end
               end
            end
            default: ;
         endcase
      end
      if (sw_rd && sw_addr == sspi_pkg::REG_BUFFER) st_nxt.bf = 1'b0;

      // master clock generation, frozen while asleep
      if (master) begin
         if (!st_r.active) begin
            st_nxt.sck_q = cpol;
         end else if (!sleep_in) begin
            if (mode == sspi_pkg::MODE_M_TIMER_TWO) begin
               if (timer_two_tick) begin   // timer output halved by toggling
                  st_nxt.sck_q = !st_r.sck_q;
                  edge_ev      = 1'b1;
                  lead         = (st_r.sck_q == cpol);
               end
            end else if (st_r.div == '0) begin
               st_nxt.div   = half_of(mode);
               st_nxt.sck_q = !st_r.sck_q;
               edge_ev      = 1'b1;
               lead         = (st_r.sck_q == cpol);
            end else begin
               st_nxt.div = st_r.div - 6'h01;
            end
         end
      end else if (link.sck != st_r.sck_prev && !(sel_ctl && link.ss_n)) begin
         edge_ev = 1'b1;   // external clock, sleep does not matter
         lead    = (link.sck != cpol);
      end

      // cke 1 shifts on trailing edges so bit 7 is out before the first edge
      chg     = lead ^ cke;
      n       = st_r.edges + 5'h01;
      byte_in = chg ? {st_r.sr[6:0], (input_sample_phase && master) ? link.dev_sdi : st_r.in_bit}
                    : {st_r.sr[6:0], link.dev_sdi};
      if (edge_ev && en) begin
         st_nxt.edges = n;
         if (n == sspi_pkg::BYTE_EDGES) begin
            // eight bits in: move to buffer unless still unread
            if (st_r.bf) begin
               st_nxt.ctl[sspi_pkg::OVF_BIT] = 1'b1;
            end else begin
               st_nxt.buffer = byte_in;
               st_nxt.bf     = 1'b1;
            end
            st_nxt.irq    = 1'b1;
            st_nxt.sr     = byte_in;
            st_nxt.edges  = '0;
            st_nxt.active = 1'b0;
         end else if (chg) begin
            if (cke || n != 5'h01) st_nxt.sr = byte_in;   // msb first
         end else if (!(input_sample_phase && master)) begin
            st_nxt.in_bit = link.dev_sdi;
         end
      end

      // module reset: disabled port, or high select with select control
      if (!en || (!master && sel_ctl && link.ss_n)) begin
         st_nxt.edges  = '0;
         st_nxt.in_bit = 1'b0;
         st_nxt.active = 1'b0;
      end

      // pins belong to the port only while enabled
      st_nxt.sck_oe_n = !(en && master);
      st_nxt.sdo_oe_n = !(en && !sdo_off && !(!master && sel_ctl && link.ss_n));
      st_nxt.wake     = st_nxt.irq && st_nxt.irq_en;
      st_nxt.rdata    = sw_rd ? rd_mux(st_r, sw_addr) : 8'h00;
   end

   // device reset clears control and status and stops any byte
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{sr: 8'h00, buffer: 8'h00, in_bit: 1'b0, edges: 5'h00, active: 1'b0, div: 6'h00,
                   sck_q: 1'b0, sck_prev: 1'b1, sck_oe_n: 1'b1, sdo_oe_n: 1'b1,
                   ctl: sspi_pkg::CTL_RESET, stat_hi: sspi_pkg::STAT_RESET, bf: 1'b0, irq: 1'b0,
                   irq_en: 1'b0, wake: 1'b0, rdata: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.dev_sck      = st_r.sck_q;
   assign link.dev_sck_oe_n = st_r.sck_oe_n;
   assign link.dev_sdo      = st_r.sr[7];
   assign link.dev_sdo_oe_n = st_r.sdo_oe_n;
   assign sw_rdata          = st_r.rdata;
   assign wake              = st_r.wake;
endmodule

// *** test/sspi_link_sva.sv ***
// assertions on the serial link between the port and its partner
`timescale 1ns/1ps
module sspi_link_sva (
   input wire logic clk,          // 200 MHz clock
   input wire logic rstn,         // async reset, active low
   input wire logic dev_sck,      // port clock value
   input wire logic dev_sck_oe_n, // port clock enable, low drives
   input wire logic par_sck,      // partner clock value
   input wire logic par_sck_oe_n, // partner clock enable, low drives
   input wire logic sck,          // resolved clock wire
   input wire logic dev_sdo,      // port data out
   input wire logic dev_sdo_oe_n, // port data enable, low drives
   input wire logic ss_n          // select from the partner
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic       drv_r;  // port drove the clock last cycle
   logic       sck_r;  // port clock last cycle
   logic [3:0] edge_r; // port clock toggles modulo one byte
   logic [6:0] gap_r;  // cycles since the last toggle, saturating
   logic       tog;    // port clock toggled while driven
   // the first driven cycle is not a toggle, so enabling with a high idle level is not counted
   assign tog = !dev_sck_oe_n && drv_r && (dev_sck != sck_r);
   // counting restarts when the port lets go, so an aborted byte leaves no trace
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         drv_r  <= 1'b0;
         sck_r  <= 1'b0;
         edge_r <= 4'h0;
         gap_r  <= 7'h00;
      end else begin
         drv_r <= !dev_sck_oe_n;
         sck_r <= dev_sck;
         if (dev_sck_oe_n) begin
            edge_r <= 4'h0;
            gap_r  <= 7'h00;
         end else if (tog) begin
            edge_r <= edge_r + 4'h1;
            gap_r  <= 7'h00;
         end else if (gap_r != 7'h40) begin
            gap_r <= gap_r + 7'h01;
         end
      end
   end
   property p_reset_release; $rose(rstn) |-> dev_sck_oe_n && dev_sdo_oe_n; endproperty
   a_reset_release: assert property (p_reset_release) else $error("pin driven right after reset");
   property p_one_driver; !dev_sck_oe_n |-> par_sck_oe_n; endproperty
   a_one_driver: assert property (p_one_driver) else $error("both ends drive the clock");
   property p_half_bit; tog |=> !tog; endproperty
   a_half_bit: assert property (p_half_bit) else $error("port clock half period too short");
   property p_whole_byte; gap_r == 7'h40 |-> edge_r == 4'h0; endproperty
   a_whole_byte: assert property (p_whole_byte) else $error("port clock stopped mid byte");
   property p_data_on_edge; !dev_sck_oe_n && !dev_sdo_oe_n && $changed(dev_sdo) && !tog |-> edge_r == 4'h0; endproperty
   a_data_on_edge: assert property (p_data_on_edge) else $error("data out moved off a clock edge");
   property p_ss_frame; !par_sck_oe_n && $stable(par_sck_oe_n) && $changed(par_sck) |-> !ss_n; endproperty
   a_ss_frame: assert property (p_ss_frame) else $error("partner clocks with select high");
   property p_partner_half; !par_sck_oe_n && $stable(par_sck_oe_n) && $changed(par_sck) |=> $stable(par_sck); endproperty
   a_partner_half: assert property (p_partner_half) else $error("partner clock too fast");
   property p_idle_pullup; dev_sck_oe_n && par_sck_oe_n |-> sck; endproperty
   a_idle_pullup: assert property (p_idle_pullup) else $error("released clock not high");
endmodule

// *** test/tb_top.sv ***
// bench: port and partner joined over the link, driven from both user sides
`timescale 1ns/1ps
module tb_top;
   // stimulus and observed outputs
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [2:0] sw_addr = 3'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic       sw_wr = 1'b0;
   logic       sw_rd = 1'b0;
   logic [7:0] sw_rdata;
   logic       sleep_in = 1'b0;
   logic       timer_two_tick = 1'b0;
   logic [1:0] tick_cnt = 2'h0;
   logic       sdo_off = 1'b0;
   logic       wake;
   logic       p_master = 1'b0;
   logic       p_cpol = 1'b0;
   logic       p_cke = 1'b0;
   logic       start = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic [7:0] rx_byte;
   logic       done;
   logic       rd_pend = 1'b0;   // read data due at this falling edge
   logic [7:0] reg_q[$];         // expected read data, oldest first
   logic [7:0] byte_q[$];        // expected partner bytes
   int         num_errors = 0;
   int         total_checks = 0;
   sspi_link_if link ();
   sspi_port sspi_port_i (.clk(clk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sleep_in(sleep_in), .timer_two_tick(timer_two_tick), .sdo_off(sdo_off),
      .wake(wake), .link(link));
   sspi_partner sspi_partner_i (.clk(clk), .rstn(rstn), .p_master(p_master), .p_cpol(p_cpol), .p_cke(p_cke),
      .p_half(8'h03), .start(start), .tx_byte(tx_byte), .rx_byte(rx_byte), .done(done), .busy(), .link(link));
   sspi_link_sva sspi_link_sva_i (.clk(clk), .rstn(rstn), .dev_sck(link.dev_sck), .dev_sck_oe_n(link.dev_sck_oe_n),
      .par_sck(link.par_sck), .par_sck_oe_n(link.par_sck_oe_n), .sck(link.sck), .dev_sdo(link.dev_sdo),
      .dev_sdo_oe_n(link.dev_sdo_oe_n), .ss_n(link.ss_n));
   always #2.5 clk = ~clk;
   // timer pulse every fourth cycle keeps the timer rate above the port's minimum half period
   always @(posedge clk) begin
      tick_cnt  <= tick_cnt + 2'h1;
      timer_two_tick <= (tick_cnt == 2'h3);
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // results are judged at the falling edge, clear of the design's own updates
   always @(negedge clk) begin
      if (rd_pend && reg_q.size() > 0) chk("register read", reg_q.pop_front(), sw_rdata);
      rd_pend = sw_rd;
      if (done === 1'b1 && byte_q.size() > 0) chk("partner byte", byte_q.pop_front(), rx_byte);
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      reg_q.push_back(e);
      @(posedge clk);
      sw_rd <= 1'b0;
   endtask
   task automatic wait_wake();
      int n;
      n = 0;
      while (wake !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk("wake", 8'h01, {7'h0, wake});
   endtask
   // port released at the same edge the partner turns round, so the clock never has two drivers
   task automatic cfg(input logic [7:0] ctl, input logic [7:0] stat, input logic pm, input logic cke);
      wr(sspi_pkg::REG_CONTROL, 8'h00);
      @(posedge clk);   // the port lets go of its clock one cycle after the write
      p_master <= pm;
      p_cpol   <= ctl[4];
      p_cke    <= cke;
      wr(sspi_pkg::REG_STATUS, stat);
      wr(sspi_pkg::REG_CONTROL, ctl);
   endtask
   task automatic run_master(input logic [3:0] mode, input logic cpol, input logic cke, input logic off);
      logic [7:0] ctl;
      logic [7:0] a;
      logic [7:0] b;
      logic       s;
      ctl = {2'h0, 1'b1, cpol, mode};
      a = 8'($urandom);
      b = 8'($urandom);
      cfg(ctl, {off, cke, 6'h00}, 1'b0, cke);
      tx_byte <= b;
      sdo_off <= off;
      byte_q.push_back(off ? 8'hff : a);
      wr(sspi_pkg::REG_BUFFER, a);
      wr(sspi_pkg::REG_BUFFER, ~a);
      if (mode == sspi_pkg::MODE_M_DIV4) begin
         sleep_in <= 1'b1;
         repeat (2) @(negedge clk);
         s = link.sck;
         repeat (20) @(negedge clk);
         chk("clock in sleep", {7'h0, s}, {7'h0, link.sck});
         @(posedge clk);
         sleep_in <= 1'b0;
      end
      wait_wake();
      rd(sspi_pkg::REG_STATUS, {off, cke, 6'h01});
      rd(sspi_pkg::REG_CONTROL, ctl | 8'h80);
      rd(sspi_pkg::REG_FLAGS, 8'h08);
      rd(sspi_pkg::REG_BUFFER, b);
      rd(sspi_pkg::REG_STATUS, {off, cke, 6'h00});
      wr(sspi_pkg::REG_FLAGS, 8'h00);
      sdo_off <= 1'b0;
   endtask
   // partner as master; the port sleeps through the whole byte
   task automatic run_slave(input logic [3:0] mode, input logic cke);
      logic [7:0] c;
      logic [7:0] d;
      c = 8'($urandom);
      d = 8'($urandom);
      cfg({3'h1, 1'b1, mode}, {1'b0, cke, 6'h00}, 1'b1, cke);
      wr(sspi_pkg::REG_BUFFER, c);
      tx_byte  <= d;
      sleep_in <= 1'b1;
      byte_q.push_back(c);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_wake();
      repeat (40) @(negedge clk);
      if (mode == sspi_pkg::MODE_S_SEL) chk("data out released", 8'h01, {7'h0, link.dev_sdo_oe_n});
      @(posedge clk);
      sleep_in <= 1'b0;
      rd(sspi_pkg::REG_BUFFER, d);
      rd(sspi_pkg::REG_FLAGS, 8'h08);
      wr(sspi_pkg::REG_FLAGS, 8'h00);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // a whole run needs under two thousand cycles
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(61));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) if (i != 2) rd(3'(i), 8'h00);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      wr(sspi_pkg::REG_ENABLES, 8'h08);
      rd(sspi_pkg::REG_ENABLES, 8'h08);
      for (int m = 0; m < 4; m++) run_master(4'(m), m[0], m[1], m == 3);
      run_slave(sspi_pkg::MODE_S_SEL, 1'b1);
      run_slave(sspi_pkg::MODE_S_NOSEL, 1'b0);
      // abort a byte by disabling, then a fresh byte must still be whole
      cfg(8'h21, 8'h00, 1'b0, 1'b0);
      wr(sspi_pkg::REG_BUFFER, 8'h5a);
      repeat (30) @(posedge clk);
      wr(sspi_pkg::REG_CONTROL, 8'h01);
      repeat (100) @(posedge clk);
      rd(sspi_pkg::REG_FLAGS, 8'h00);
      wr(sspi_pkg::REG_CONTROL, 8'h21);
      wr(sspi_pkg::REG_BUFFER, 8'h3c);
      wait_wake();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(sspi_pkg::REG_CONTROL, 8'h00);
      rd(sspi_pkg::REG_ENABLES, 8'h00);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule
